// [bench/rcd_ctrl_model.sv]
// Memory controller model driving command, address and delayed parity
`timescale 1ns/1ps
module rcd_ctrl_model (
    // Clock
    input  wire logic        clk_sys,
    // Command, address and controls towards the register
    output logic [15:0]      addr,
    output logic [2:0]       bank,
    output logic [2:0]       cmd_n,
    output logic [3:0]       sel_n,
    output logic [1:0]       cke,
    output logic [1:0]       odt,
    output logic             par
);
    logic bad_q;
    initial begin
        addr  = 16'h0000;
        bank  = 3'h0;
        cmd_n = 3'h7;
        sel_n = 4'hF;
        cke   = 2'h0;
        odt   = 2'h0;
        par   = 1'h0;
        bad_q = 1'h0;
    end
    always @(negedge clk_sys) begin
        par <= ^{addr, bank, cmd_n} ^ bad_q;
    end
    // one select per command, except refusal tests
    task automatic issue(input logic [3:0] s, input logic [15:0] a, input logic [1:0] c, input logic bad);
        @(negedge clk_sys);
        sel_n <= s;
        cke   <= c;
        odt   <= ~c;
        bad_q <= bad;
        // Unselected lines toggle so stale data never looks valid
        addr  <= (s == 4'hF) ? ~addr : a;
        bank  <= (s == 4'hF) ? ~bank : a[2:0];
        cmd_n <= (s == 4'hF) ? ~cmd_n : a[5:3];
    endtask : issue
endmodule : rcd_ctrl_model

// [bench/test_command_address_register_parity.sv]
// Self-checking bench for the command/address register
`timescale 1ns/1ps
module test_command_address_register_parity;
    import rcd_pkg::*;
    logic clk_sys, rst, ck_t, ck_c, mir, quad_n, grp_a, grp_b, flt, t3;
    logic [15:0] addr, oa;
    logic [2:0]  bank, cmd_n, oba, ostr;
    logic [3:0]  sel_n;
    logic [1:0]  cke, odt, osa, osb, ckea, ckeb, odta;
    logic        par, oea, oeb, flag_n, iterm, qmode_n, ctla, foe, ck_run;
    logic [1:0]  ck_div = 2'h0;
    int          fail_count = 0;
    int          n_tests = 0;

    rcd_ctrl_model i_ctl (.clk_sys(clk_sys), .addr(addr), .bank(bank), .cmd_n(cmd_n), .sel_n(sel_n),
        .cke(cke), .odt(odt), .par(par));
    rcd_cmd_addr i_dut (.clk_sys(clk_sys), .rst(rst), .in_clk_enable(cke), .in_term_control(odt),
        .in_addr_bits(addr), .in_bank_bits(bank), .in_row_strobe_n(cmd_n[2]), .in_col_strobe_n(cmd_n[1]),
        .in_write_strobe_n(cmd_n[0]), .in_select_0_n(sel_n[0]), .in_select_1_n(sel_n[1]),
        .in_select_2_n(sel_n[2]), .in_select_3_n(sel_n[3]), .parity_bit_in(par),
        .ballout_swap_select(mir), .four_select_mode_pin_n(quad_n), .ck_true_pin(ck_t), .ck_comp_pin(ck_c),
        .group_a_enable(grp_a), .group_b_enable(grp_b), .float_enable_bit(flt), .three_cycle_timing(t3),
        .out_addr_bits_a(oa), .out_bank_bits_a(oba), .out_row_strobe_n_a(ostr[2]), .out_col_strobe_n_a(ostr[1]),
        .out_write_strobe_n_a(ostr[0]), .out_select_n_a(osa), .out_clk_enable_a(ckea), .out_term_control_a(odta),
        .out_cmd_oe_a(oea), .out_ctrl_oe_a(ctla), .out_addr_bits_b(), .out_bank_bits_b(),
        .out_row_strobe_n_b(), .out_col_strobe_n_b(), .out_write_strobe_n_b(), .out_select_n_b(osb),
        .out_clk_enable_b(ckeb), .out_term_control_b(), .out_cmd_oe_b(oeb), .out_ctrl_oe_b(),
        .parity_error_flag_n(flag_n), .parity_error_flag_oe(foe), .input_termination(iterm),
        .four_select_mode_n(qmode_n));

    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    // clock pin pair keeps toggling while running, never parked
    always @(negedge clk_sys) begin
        ck_div <= ck_div + 2'h1;
        ck_t   <= ck_run & ck_div[1];
        ck_c   <= ck_run & ~ck_div[1];
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task automatic idle(input int n);
        repeat (n) i_ctl.issue(4'hF, 16'h0000, 2'h0, 1'h0);
    endtask : idle

    task automatic t_fwd();
        i_ctl.issue(4'hE, 16'hA5C3, 2'h1, 1'h0);
        i_ctl.issue(4'hF, 16'h0000, 2'h2, 1'h0);
        check(oa, 16'hA5C3, "forwarded address");
        check(oba, 3'h3, "forwarded bank");
        check(osa, 2'h2, "select copy");
        check(ckea, 2'h1, "clock enable");
        check(odta, 2'h2, "term control");
        i_ctl.issue(4'hF, 16'h0000, 2'h3, 1'h0);
        check(oa, 16'hA5C3, "held with no select");
        check(osa, 2'h3, "idle selects");
        check(ckea, 2'h2, "clock enable unselected");
        check(odta, 2'h1, "term control unselected");
        $display("done: forward");
    endtask : t_fwd

    task automatic t_sel();
        i_ctl.issue(4'hC, 16'h1234, 2'h0, 1'h0);
        i_ctl.issue(4'hB, 16'h4321, 2'h0, 1'h0);
        check(oa, 16'hA5C3, "both low holds");
        check(osa, 2'h3, "both low selects");
        idle(1);
        check(oa, 16'hA5C3, "upper select ignored");
        quad_n = 1'h0;
        idle(6);
        check(qmode_n, 1'h0, "four-select status");
        i_ctl.issue(4'hB, 16'h4321, 2'h0, 1'h0);
        idle(1);
        check(oa, 16'h4321, "quad forward");
        check(osb, 2'h2, "quad upper selects");
        quad_n = 1'h1;
        idle(6);
        $display("done: selects");
    endtask : t_sel

    task automatic t_par(input logic bad);
        i_ctl.issue(4'hE, 16'h0001, 2'h0, bad);
        for (int k = 1; k <= 5; k++) begin
            idle(1);
            check(flag_n, (bad && (k == 3 || k == 4)) ? 1'h0 : 1'h1, "error flag");
            check(foe, (bad && (k == 3 || k == 4)) ? 1'h1 : 1'h0, "error flag enable");
        end
        $display("done: parity");
    endtask : t_par

    task automatic t_float();
        flt = 1'h1;
        idle(2);
        check(oea, 1'h0, "float when idle");
        check(ctla, 1'h1, "selects still driven");
        t3 = 1'h1;
        i_ctl.issue(4'hE, 16'h0F0F, 2'h0, 1'h0);
        idle(2);
        check(oea, 1'h1, "no float in three-cycle timing");
        t3 = 1'h0;
        flt = 1'h0;
        grp_b = 1'h0;
        i_ctl.issue(4'hD, 16'h00F0, 2'h1, 1'h0);
        idle(1);
        check(oeb, 1'h0, "group B off");
        check(oea, 1'h1, "group A on");
        check(ckeb, 2'h1, "group B clock enable");
        check(ostr, 3'h6, "forwarded strobes");
        grp_b = 1'h1;
        $display("done: float and groups");
    endtask : t_float

    task automatic t_pins();
        mir = 1'h1;
        idle(6);
        check(iterm, 1'h0, "termination off");
        i_ctl.issue(4'hE, 16'h0028, 2'h0, 1'h0);
        idle(1);
        check(oa, 16'h0050, "mirrored address");
        mir = 1'h0;
        ck_run = 1'h0;
        idle(6);
        check(iterm, 1'h1, "termination on");
        check(oea, 1'h0, "clock stop floats");
        check(ctla, 1'h0, "clock stop floats selects");
        check(ckea, 2'h0, "clock stop enable low");
        ck_run = 1'h1;
        idle(8);
        check(oea, 1'h1, "clock restart drives");
        $display("done: pins");
    endtask : t_pins

    initial begin
        {rst, ck_run, mir, quad_n, grp_a, grp_b, flt, t3} = 8'hDC;
        repeat (10) @(negedge clk_sys);
        check(oea, 1'h0, "reset floats");
        check(flag_n, 1'h1, "reset flag");
        rst = 1'h0;
        idle(1);
        check(oa, 16'h0000, "driven low after reset");
        check(flag_n, 1'h1, "flag idle after reset");
        check(oea, 1'h1, "outputs driven after reset");
        idle(5);
        $display("done: reset");
        t_fwd();
        t_sel();
        t_par(1'h0);
        t_par(1'h1);
        t_float();
        t_pins();
        test_done();
    end

    // Whole run is under a hundred cycles
    initial begin
        #(40 * 3000);
        fail_count++;
        test_done();
    end
endmodule : test_command_address_register_parity

// [hdl/rcd_cmd_addr.sv]
// Chip-select gated command/address register with even parity check
`timescale 1ns/1ps
module rcd_cmd_addr
    import rcd_pkg::*;
#(
    parameter int ADDR_W = RCD_ADDR_W,
    parameter int BANK_W = RCD_BANK_W,
    parameter int CKE_W  = RCD_CKE_W
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Ungated controls
    input  wire logic [CKE_W-1:0]  in_clk_enable,
    input  wire logic [CKE_W-1:0]  in_term_control,
    // Select-gated command and address
    input  wire logic [ADDR_W-1:0] in_addr_bits,
    input  wire logic [BANK_W-1:0] in_bank_bits,
    input  wire logic              in_row_strobe_n,
    input  wire logic              in_col_strobe_n,
    input  wire logic              in_write_strobe_n,
    input  wire logic              in_select_0_n,
    input  wire logic              in_select_1_n,
    input  wire logic              in_select_2_n,
    input  wire logic              in_select_3_n,
    input  wire logic              parity_bit_in,
    // Straps and clock pins
    input  wire logic              ballout_swap_select,
    input  wire logic              four_select_mode_pin_n,
    input  wire logic              ck_true_pin,
    input  wire logic              ck_comp_pin,
    // Control word zero settings
    input  wire logic              group_a_enable,
    input  wire logic              group_b_enable,
    input  wire logic              float_enable_bit,
    input  wire logic              three_cycle_timing,
    // Group A outputs
    output logic [ADDR_W-1:0]      out_addr_bits_a,
    output logic [BANK_W-1:0]      out_bank_bits_a,
    output logic                   out_row_strobe_n_a,
    output logic                   out_col_strobe_n_a,
    output logic                   out_write_strobe_n_a,
    output logic [1:0]             out_select_n_a,
    output logic [CKE_W-1:0]       out_clk_enable_a,
    output logic [CKE_W-1:0]       out_term_control_a,
    output logic                   out_cmd_oe_a,
    output logic                   out_ctrl_oe_a,
    // Group B outputs
    output logic [ADDR_W-1:0]      out_addr_bits_b,
    output logic [BANK_W-1:0]      out_bank_bits_b,
    output logic                   out_row_strobe_n_b,
    output logic                   out_col_strobe_n_b,
    output logic                   out_write_strobe_n_b,
    output logic [1:0]             out_select_n_b,
    output logic [CKE_W-1:0]       out_clk_enable_b,
    output logic [CKE_W-1:0]       out_term_control_b,
    output logic                   out_cmd_oe_b,
    output logic                   out_ctrl_oe_b,
    // Status
    output logic                   parity_error_flag_n,
    output logic                   parity_error_flag_oe,
    output logic                   input_termination,
    output logic                   four_select_mode_n
);
    localparam int CMD_W = ADDR_W + BANK_W + RCD_STROBE_W;

    // Forwarding needs at most one low select in each half
    function automatic logic cs_forward(input logic [RCD_CS_W-1:0] cs);
        logic [1:0] lo_a;
        logic [1:0] lo_b;
        lo_a = ~cs[1:0];
        lo_b = ~cs[3:2];
        return !(&lo_a) && !(&lo_b) && (|lo_a || |lo_b);
    endfunction : cs_forward

    // Standard mirrored pairs: 3/4, 5/6, 7/8 swap places
    function automatic logic [ADDR_W-1:0] ballout_swap_select_addr(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] m;
        m    = a;
        m[3] = a[4];
        m[4] = a[3];
        m[5] = a[6];
        m[6] = a[5];
        m[7] = a[8];
        m[8] = a[7];
        return m;
    endfunction : ballout_swap_select_addr

    // Pin synchronisers; a level counts once stages two and three agree
    logic [RCD_PIN_COUNT-1:0]  pin_raw;
    logic [RCD_SYNC_DEPTH-1:0] pin_sync_q [RCD_PIN_COUNT];
    logic [RCD_PIN_COUNT-1:0]  pin_stable_q;

    assign pin_raw = {ck_comp_pin, ck_true_pin, four_select_mode_pin_n, ballout_swap_select};

    genvar gp;
    generate
        for (gp = 0; gp < RCD_PIN_COUNT; gp++) begin : g_pin
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    pin_sync_q[gp]   <= {RCD_SYNC_DEPTH{RCD_PIN_RST[gp]}};
                    pin_stable_q[gp] <= RCD_PIN_RST[gp];
                end else begin
                    pin_sync_q[gp] <= {pin_sync_q[gp][RCD_SYNC_DEPTH-2:0], pin_raw[gp]};
                    if (pin_sync_q[gp][1] == pin_sync_q[gp][2]) begin
                        pin_stable_q[gp] <= pin_sync_q[gp][2];
                    end
                end
            end
        end
    endgenerate

    // mode strap, low means four selects
    wire                    four_select_mode = !pin_stable_q[RCD_PIN_QUAD_N];
    wire                    ballout_swap_select_on        = pin_stable_q[RCD_PIN_BALLOUT_SWAP_SELECT];
    // stopped clock; sampled pins, so only a slow stop is seen
    wire                    clk_stop         = !pin_stable_q[RCD_PIN_CK_T] && !pin_stable_q[RCD_PIN_CK_C];

    wire [RCD_CS_W-1:0]     cs_raw = {in_select_3_n, in_select_2_n, in_select_1_n, in_select_0_n};
    // upper selects masked in dual mode
    wire [RCD_CS_W-1:0]     cs_eff = four_select_mode ? cs_raw : {RCD_CS_IDLE, cs_raw[1:0]};
    // forward only on a legal select pattern
    wire                    fwd      = cs_forward(cs_eff);
    wire                    any_low  = !(&cs_eff);
    // floating is blocked under three-cycle timing
    wire                    float_req = !any_low && float_enable_bit && !three_cycle_timing;
    wire [ADDR_W-1:0]       addr_log = ballout_swap_select_on ? ballout_swap_select_addr(in_addr_bits) : in_addr_bits;
    wire [CMD_W-1:0]        cmd_in   = {addr_log, in_bank_bits, in_row_strobe_n, in_col_strobe_n,
                                        in_write_strobe_n};
    wire [RCD_GROUPS-1:0]   grp_en   = {group_b_enable, group_a_enable};
    wire [1:0]              cs_grp [RCD_GROUPS];

    assign cs_grp[0] = cs_eff[1:0];
    assign cs_grp[1] = four_select_mode ? cs_eff[3:2] : cs_eff[1:0];

    // Output registers per group
    logic [CMD_W-1:0]       cmd_q  [RCD_GROUPS];
    logic [1:0]             cs_q   [RCD_GROUPS];
    logic [CKE_W-1:0]       cke_q  [RCD_GROUPS];
    logic [CKE_W-1:0]       odt_q  [RCD_GROUPS];
    logic [RCD_GROUPS-1:0]  cmd_oe_q;
    logic [RCD_GROUPS-1:0]  ctrl_oe_q;

    genvar gg;
    generate
        for (gg = 0; gg < RCD_GROUPS; gg++) begin : g_grp
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    // reset floats outputs; data waits low
                    cmd_q[gg]     <= '0;
                    cs_q[gg]      <= '0;
                    cke_q[gg]     <= '0;
                    odt_q[gg]     <= '0;
                    cmd_oe_q[gg]  <= 1'b0;
                    ctrl_oe_q[gg] <= 1'b0;
                end else begin
                    // one register stage; data holds and selects go idle when not forwarding
                    if (fwd) begin
                        cmd_q[gg] <= cmd_in;
                    end
                    cs_q[gg]      <= fwd ? cs_grp[gg] : RCD_CS_IDLE;
                    // ungated controls; clock-enable low on stop
                    cke_q[gg]     <= clk_stop ? '0 : in_clk_enable;
                    odt_q[gg]     <= in_term_control;
                    cmd_oe_q[gg]  <= grp_en[gg] && !clk_stop && !float_req;
                    ctrl_oe_q[gg] <= grp_en[gg] && !clk_stop;
                end
            end
        end
    endgenerate

    assign {out_addr_bits_a, out_bank_bits_a, out_row_strobe_n_a, out_col_strobe_n_a,
            out_write_strobe_n_a} = cmd_q[0];
    assign {out_addr_bits_b, out_bank_bits_b, out_row_strobe_n_b, out_col_strobe_n_b,
            out_write_strobe_n_b} = cmd_q[1];
    assign out_select_n_a     = cs_q[0];
    assign out_select_n_b     = cs_q[1];
    assign out_clk_enable_a   = cke_q[0];
    assign out_clk_enable_b   = cke_q[1];
    assign out_term_control_a = odt_q[0];
    assign out_term_control_b = odt_q[1];
    assign out_cmd_oe_a       = cmd_oe_q[0];
    assign out_cmd_oe_b       = cmd_oe_q[1];
    assign out_ctrl_oe_a      = ctrl_oe_q[0];
    assign out_ctrl_oe_b      = ctrl_oe_q[1];

    // Parity pipeline: data captured, parity bit follows a cycle later
    logic [CMD_W-1:0]       par_vec_q;
    logic                   par_chk_q;
    logic                   detect_q;
    rcd_err_state_t         err_state_q;
    rcd_err_state_t         err_state_d;
    logic                   flag_n_q;
    logic                   flag_oe_q;
    logic                   term_q;
    logic                   mode_n_q;

    // even parity over gated data and delayed bit
    wire                    par_bad = par_chk_q && (^{par_vec_q, parity_bit_in});

    always_comb begin
        case (err_state_q)
            RCD_ERR_IDLE:   err_state_d = RCD_ERR_IDLE;
            RCD_ERR_FIRST:  err_state_d = RCD_ERR_SECOND;
            RCD_ERR_SECOND: err_state_d = RCD_ERR_IDLE;
            default:        err_state_d = RCD_ERR_IDLE;
        endcase
        // a new error restarts the two-cycle pulse
        if (detect_q) begin
            err_state_d = RCD_ERR_FIRST;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            par_vec_q   <= '0;
            par_chk_q   <= 1'b0;
            detect_q    <= 1'b0;
            err_state_q <= RCD_ERR_IDLE;
            flag_n_q    <= RCD_FLAG_RST;
            flag_oe_q   <= 1'b0;
            term_q      <= RCD_TERM_RST;
            mode_n_q    <= RCD_PIN_RST[RCD_PIN_QUAD_N];
        end else begin
            // check any cycle with one or more effective selects low
            par_vec_q   <= cmd_in;
            par_chk_q   <= any_low;
            // detect, state, flag: three edges after the bad cycle
            detect_q    <= par_bad;
            err_state_q <= err_state_d;
            flag_n_q    <= (err_state_d == RCD_ERR_IDLE);
            flag_oe_q   <= (err_state_d != RCD_ERR_IDLE);
            // termination is off while ballout_swap_select is on, for address and command
            term_q      <= !ballout_swap_select_on;
            mode_n_q    <= !four_select_mode;
        end
    end

    assign parity_error_flag_n  = flag_n_q;
    assign parity_error_flag_oe = flag_oe_q;
    assign input_termination    = term_q;
    assign four_select_mode_n   = mode_n_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    cke_follows_a: assert property (!clk_stop |=> out_clk_enable_a == $past(in_clk_enable))
        else $error("clock enable not forwarded");
    fwd_data_a: assert property (fwd |-> ##RCD_REG_LATENCY out_addr_bits_b == $past(addr_log))
        else $error("forwarded address mismatch");
    hold_data_a: assert property (!fwd |=> out_addr_bits_a == $past(out_addr_bits_a)
                                         && out_select_n_a == RCD_CS_IDLE)
        else $error("gated outputs not held");
    dual_ignore_a: assert property ((!four_select_mode && in_select_0_n && in_select_1_n)
                                    |=> out_select_n_b == RCD_CS_IDLE)
        else $error("upper select used in dual mode");
    group_off_a: assert property (!group_b_enable |=> !out_cmd_oe_b && !out_ctrl_oe_b)
        else $error("disabled group still driven");
    err_delay_a: assert property (par_bad |-> ##2 !parity_error_flag_n)
        else $error("error flag late");
    err_width_a: assert property ($fell(parity_error_flag_n) |=> !parity_error_flag_n)
        else $error("error pulse too short");
    err_end_a: assert property ((err_state_q == RCD_ERR_SECOND && !detect_q) |=> parity_error_flag_n)
        else $error("error pulse too long");
    float_idle_a: assert property (float_req |=> !out_cmd_oe_a && !out_cmd_oe_b
                                   && out_ctrl_oe_a == ($past(group_a_enable) && !$past(clk_stop)))
        else $error("idle float wrong");
    clk_stop_a: assert property (clk_stop |=> !out_ctrl_oe_a && out_clk_enable_b == '0)
        else $error("stopped clock not handled");
    term_ballout_swap_select_a: assert property (ballout_swap_select_on |=> !input_termination)
        else $error("termination on while mirrored");
    reset_out_a: assert property (@(posedge clk_sys) disable iff (1'b0)
                                  $past(rst) |-> (!out_cmd_oe_a && parity_error_flag_n && out_addr_bits_a == '0))
        else $error("reset state wrong");
    mode_status_a: assert property (four_select_mode |=> !four_select_mode_n)
        else $error("mode status not shown");
    ballout_swap_select_swap_a: assert property ((fwd && ballout_swap_select_on) |=> out_addr_bits_a[3] == $past(in_addr_bits[4])
                                    && out_addr_bits_a[4] == $past(in_addr_bits[3]))
        else $error("mirrored address not swapped");
    dual_copy_a: assert property ((fwd && !four_select_mode) |=> out_select_n_a == out_select_n_b)
        else $error("select copies differ in dual mode");
endmodule : rcd_cmd_addr

// [hdl/rcd_pkg.sv]
// Shared constants for the registered command/address path with parity
package rcd_pkg;
    localparam int          RCD_ADDR_W      = 16;
    localparam int          RCD_BANK_W      = 3;
    localparam int          RCD_CKE_W       = 2;
    localparam int          RCD_CS_W        = 4;
    localparam int          RCD_STROBE_W    = 3;
    localparam int          RCD_GROUPS      = 2;
    // Cycles from input capture to re-driven output
    localparam int          RCD_REG_LATENCY = 1;
    // Cycles from the bad input cycle to the flag, and flag width
    localparam int          RCD_ERR_LATENCY = 3;
    localparam int          RCD_ERR_PULSE   = 2;
    // Pin synchroniser depth and strap pin positions
    localparam int          RCD_SYNC_DEPTH  = 3;
    localparam int          RCD_PIN_COUNT   = 4;
    localparam int          RCD_PIN_BALLOUT_SWAP_SELECT  = 0;
    localparam int          RCD_PIN_QUAD_N  = 1;
    localparam int          RCD_PIN_CK_T    = 2;
    localparam int          RCD_PIN_CK_C    = 3;
    // Reset levels: no ballout_swap_select, dual-select default, clock running
    localparam logic [3:0]  RCD_PIN_RST     = 4'h6;
    localparam logic        RCD_FLAG_RST    = 1'b1;
    localparam logic        RCD_TERM_RST    = 1'b1;
    localparam logic [1:0]  RCD_CS_IDLE     = 2'h3;

    typedef enum logic [1:0] {
        RCD_ERR_IDLE,
        RCD_ERR_FIRST,
        RCD_ERR_SECOND
    } rcd_err_state_t;
endpackage : rcd_pkg
